// ===== include/pfta_defs.svh
`ifndef PFTA_DEFS_SVH
`define PFTA_DEFS_SVH

`define PFTA_RESET_VECTOR 14'h0000
`define PFTA_WORDS_SMALL 8192
`define PFTA_WORDS_LARGE 16384
`define PFTA_PAGE_SMALL 32
`define PFTA_PAGE_LARGE 64
`define PFTA_ERASED_WORD 16'hffff
`define PFTA_TBL_CYCLES 2
`define PFTA_LOW_BYTE 7:0
`define PFTA_HIGH_BYTE 15:8

`endif

// ===== include/pfta_pkg.sv
package pfta_pkg;
	typedef enum logic [1:0] {
		PFTA_BOOT = 2'b00,
		PFTA_IDLE = 2'b01,
		PFTA_TBL = 2'b11,
		PFTA_IAP = 2'b10
	} pfta_state_t;

	typedef enum logic [1:0] {
		PFTA_OP_READ = 2'b00,
		PFTA_OP_WRITE = 2'b01,
		PFTA_OP_ERASE = 2'b10,
		PFTA_OP_NONE = 2'b11
	} pfta_op_t;
endpackage

// ===== include/pfta_if.sv
`timescale 1ns/100ps
`default_nettype none
interface pfta_if;
	import pfta_pkg::*;
	logic ptrWr;
	logic ptrHighSel;
	logic [7:0] ptrData;
	logic latchWr;
	logic [7:0] latchData;
	logic rdReq;
	logic rdExt;
	logic [7:0] rdDest;
	logic [1:0] rdSector;
	logic iapReq;
	pfta_op_t iapOp;
	logic [13:0] iapAddr;
	logic iapLoad;
	logic [15:0] iapLoadData;
	logic busy;
	logic rdDone;
	logic rdRefused;
	logic [7:0] rdLow;
	logic [7:0] rdDestOut;
	logic [7:0] latchValue;
	logic [7:0] ptrLow;
	logic [7:0] ptrHigh;
	logic bootValid;
	logic [13:0] bootAddr;
	logic [15:0] bootWord;
	logic iapDone;
	logic [15:0] iapData;

	modport dev (
		input ptrWr, ptrHighSel, ptrData, latchWr, latchData, rdReq, rdExt, rdDest, rdSector,
		input iapReq, iapOp, iapAddr, iapLoad, iapLoadData,
		output busy, rdDone, rdRefused, rdLow, rdDestOut, latchValue, ptrLow, ptrHigh,
		output bootValid, bootAddr, bootWord, iapDone, iapData
	);
	modport core (
		output ptrWr, ptrHighSel, ptrData, latchWr, latchData, rdReq, rdExt, rdDest, rdSector,
		output iapReq, iapOp, iapAddr, iapLoad, iapLoadData,
		input busy, rdDone, rdRefused, rdLow, rdDestOut, latchValue, ptrLow, ptrHigh,
		input bootValid, bootAddr, bootWord, iapDone, iapData
	);
endinterface
`default_nettype wire

// ===== core/pfta_device.sv
`timescale 1ns/100ps
`default_nettype none
`include "pfta_defs.svh"

// Notes on behaviour
// - memory of 16-bit words, 8K or 16K
// - fetch begins at word zero after reset
// - table address is pointer high over low
// - low byte to destination, high to latch
// - normal reads only for sector 0 destinations
// - table-high latch readable and writable
// - table instructions take two cycles
// - software masks interrupts around main-routine reads; here pfta_core_end raises intBlock itself
// - serial programming: one data pin, one clock
// - programmer alone drives pins while programming
// - debug clock pin is input only
// - emulation: shared pin functions ignored
// - in-application access reaches any word
// - erase clears one page of 32/64
// - write programs block of 32/64 words
// - read returns exactly one word
module pfta_device
	import pfta_pkg::*;
#(
	parameter bit LARGE = 1'b0,
	parameter bit EMULATION = 1'b0
) (
	input wire logic clk,
	input wire logic sys_rst,
	pfta_if.dev bus,
	input wire logic progActive,
	input wire logic serialClk,
	input wire logic serialDataIn,
	output logic serialDataOut,
	output logic serialDataOe,
	input wire logic pinShareOut,
	input wire logic pinShareOe,
	output logic [15:0] serialWord,
	output logic [7:0] serialBitCount
);
	localparam int WORDS = LARGE ? `PFTA_WORDS_LARGE : `PFTA_WORDS_SMALL;
	localparam int PAGE = LARGE ? `PFTA_PAGE_LARGE : `PFTA_PAGE_SMALL;
	localparam int AW = $clog2(WORDS);
	localparam int PW = $clog2(PAGE);

	logic [15:0] mem [0:WORDS-1];
	pfta_state_t state;
	pfta_op_t op;
	logic [AW-1:0] opAddr;
	logic [PW-1:0] stepCnt;
	logic [PW-1:0] loadIdx;
	logic [15:0] wrBuf [0:PAGE-1];
	logic [15:0] rdWord;
	logic phase;
	logic bootPhase;
	logic memWe;
	logic [15:0] memWd;
	logic [AW-1:0] memWa;
	logic [AW-1:0] tblAddr;
	logic [AW-1:0] pageBase;
	logic [AW-1:0] rdAddr;
	logic [2:0] clkSync;
	logic [1:0] dataSync;
	logic [1:0] progSync;

	assign tblAddr = AW'({bus.ptrHigh, bus.ptrLow});
	assign pageBase = AW'(bus.iapAddr) & ~AW'(PAGE - 1);

	// one read port serves boot, table and in-application reads
	always_comb begin
		rdAddr = opAddr;
		if (state == PFTA_BOOT) begin
			rdAddr = AW'(`PFTA_RESET_VECTOR);
		end
	end

	always_comb begin
		memWe = 1'b0;
		memWd = `PFTA_ERASED_WORD;
		memWa = opAddr | AW'(stepCnt);
		if (state == PFTA_IAP && op == PFTA_OP_WRITE) begin
			memWe = 1'b1;
			memWd = wrBuf[stepCnt];
		end else if (state == PFTA_IAP && op == PFTA_OP_ERASE) begin
			memWe = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (memWe) begin
			mem[memWa] <= memWd;
		end
		rdWord <= mem[rdAddr];
	end

	always_ff @(posedge clk) begin
		if (bus.iapLoad && state == PFTA_IDLE) begin
			wrBuf[loadIdx] <= bus.iapLoadData;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			loadIdx <= '0;
		end else if (state == PFTA_IAP && op == PFTA_OP_WRITE) begin
			loadIdx <= '0;
		end else if (bus.iapLoad && state == PFTA_IDLE) begin
			loadIdx <= loadIdx + PW'(1);
		end
	end

	// pointer registers change only on explicit writes, never by a read
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus.ptrLow <= 8'h00;
			bus.ptrHigh <= 8'h00;
		end else if (bus.ptrWr) begin
			if (bus.ptrHighSel) begin
				bus.ptrHigh <= bus.ptrData;
			end else begin
				bus.ptrLow <= bus.ptrData;
			end
		end
	end

	// a table read completing in the same cycle overrides a software write
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus.latchValue <= 8'h00;
		end else if (state == PFTA_TBL && phase) begin
			bus.latchValue <= rdWord[`PFTA_HIGH_BYTE];
		end else if (bus.latchWr) begin
			bus.latchValue <= bus.latchData;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= PFTA_BOOT;
			op <= PFTA_OP_NONE;
			opAddr <= '0;
			stepCnt <= '0;
			phase <= 1'b0;
			bootPhase <= 1'b0;
			bus.busy <= 1'b1;
			bus.rdDone <= 1'b0;
			bus.rdRefused <= 1'b0;
			bus.rdLow <= 8'h00;
			bus.rdDestOut <= 8'h00;
			bus.bootValid <= 1'b0;
			bus.bootAddr <= `PFTA_RESET_VECTOR;
			bus.bootWord <= 16'h0000;
			bus.iapDone <= 1'b0;
			bus.iapData <= 16'h0000;
		end else begin
			bus.rdDone <= 1'b0;
			bus.rdRefused <= 1'b0;
			bus.bootValid <= 1'b0;
			bus.iapDone <= 1'b0;
			unique case (state)
				PFTA_BOOT: begin
					bootPhase <= 1'b1;
					if (bootPhase) begin
						bus.bootValid <= 1'b1;
						bus.bootWord <= rdWord;
						bus.busy <= 1'b0;
						state <= PFTA_IDLE;
					end
				end
				PFTA_IDLE: begin
					phase <= 1'b0;
					stepCnt <= '0;
					if (bus.rdReq && !bus.rdExt && bus.rdSector != 2'b00) begin
						bus.rdRefused <= 1'b1;
					end else if (bus.rdReq) begin
						opAddr <= tblAddr;
						bus.rdDestOut <= bus.rdDest;
						bus.busy <= 1'b1;
						state <= PFTA_TBL;
					end else if (bus.iapReq && bus.iapOp != PFTA_OP_NONE) begin
						op <= bus.iapOp;
						opAddr <= (bus.iapOp == PFTA_OP_READ) ? AW'(bus.iapAddr) : pageBase;
						bus.busy <= 1'b1;
						state <= PFTA_IAP;
					end
				end
				PFTA_TBL: begin
					phase <= 1'b1;
					if (phase) begin
						bus.rdLow <= rdWord[`PFTA_LOW_BYTE];
						bus.rdDone <= 1'b1;
						bus.busy <= 1'b0;
						state <= PFTA_IDLE;
					end
				end
				PFTA_IAP: begin
					if (op == PFTA_OP_READ) begin
						phase <= 1'b1;
						if (phase) begin
							bus.iapData <= rdWord;
							bus.iapDone <= 1'b1;
							bus.busy <= 1'b0;
							op <= PFTA_OP_NONE;
							state <= PFTA_IDLE;
						end
					end else begin
						stepCnt <= stepCnt + PW'(1);
						if (stepCnt == PW'(PAGE - 1)) begin
							bus.iapDone <= 1'b1;
							bus.busy <= 1'b0;
							op <= PFTA_OP_NONE;
							state <= PFTA_IDLE;
						end
					end
				end
			endcase
		end
	end

	// pins from the programmer are asynchronous: two stages before use
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			clkSync <= 3'b000;
			dataSync <= 2'b00;
			progSync <= 2'b00;
		end else begin
			clkSync <= {clkSync[1:0], serialClk};
			dataSync <= {dataSync[0], serialDataIn};
			progSync <= {progSync[0], progActive};
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			serialWord <= 16'h0000;
			serialBitCount <= 8'h00;
		end else if (!progSync[1]) begin
			serialBitCount <= 8'h00;
		end else if (clkSync[1] && !clkSync[2]) begin
			serialWord <= {serialWord[14:0], dataSync[1]};
			serialBitCount <= serialBitCount + 8'h01;
		end
	end

	// the shared pin function is dropped while programming or on emulation
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			serialDataOut <= 1'b0;
			serialDataOe <= 1'b0;
		end else begin
			serialDataOut <= pinShareOut;
			serialDataOe <= pinShareOe && !progSync[1] && !EMULATION;
		end
	end
endmodule // pfta_device
`default_nettype wire

// ===== core/pfta_core_end.sv
`timescale 1ns/100ps
`default_nettype none
`include "pfta_defs.svh"

module pfta_core_end
	import pfta_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	pfta_if.core bus,
	input wire logic setPtrLow,
	input wire logic setPtrHigh,
	input wire logic setLatch,
	input wire logic [7:0] wrValue,
	input wire logic execRead,
	input wire logic [7:0] destAddr,
	input wire logic [1:0] destSector,
	input wire logic inInterrupt,
	input wire logic iapStart,
	input wire pfta_op_t iapKind,
	input wire logic [13:0] iapTarget,
	input wire logic iapPush,
	input wire logic [15:0] iapWord,
	output logic dmWr,
	output logic [7:0] dmAddr,
	output logic [7:0] dmData,
	output logic intBlock,
	output logic [7:0] latchRead,
	output logic ready
);
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus.ptrWr <= 1'b0;
			bus.ptrHighSel <= 1'b0;
			bus.ptrData <= 8'h00;
			bus.latchWr <= 1'b0;
			bus.latchData <= 8'h00;
		end else begin
			bus.ptrWr <= setPtrLow || setPtrHigh;
			bus.ptrHighSel <= setPtrHigh;
			bus.ptrData <= wrValue;
			bus.latchWr <= setLatch;
			bus.latchData <= wrValue;
		end
	end

	// requests are offered only while the device is idle
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus.rdReq <= 1'b0;
			bus.rdExt <= 1'b0;
			bus.rdDest <= 8'h00;
			bus.rdSector <= 2'b00;
			bus.iapReq <= 1'b0;
			bus.iapOp <= PFTA_OP_NONE;
			bus.iapAddr <= 14'h0000;
			bus.iapLoad <= 1'b0;
			bus.iapLoadData <= 16'h0000;
		end else begin
			bus.rdReq <= execRead && !bus.busy && !bus.rdReq;
			bus.rdExt <= destSector != 2'b00;
			bus.rdDest <= destAddr;
			bus.rdSector <= destSector;
			bus.iapReq <= iapStart && !bus.busy && !bus.iapReq && !execRead;
			bus.iapOp <= iapKind;
			bus.iapAddr <= iapTarget;
			bus.iapLoad <= iapPush && !bus.busy;
			bus.iapLoadData <= iapWord;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dmWr <= 1'b0;
			dmAddr <= 8'h00;
			dmData <= 8'h00;
			latchRead <= 8'h00;
			ready <= 1'b0;
		end else begin
			dmWr <= bus.rdDone;
			dmAddr <= bus.rdDestOut;
			dmData <= bus.rdLow;
			latchRead <= bus.latchValue;
			ready <= !bus.busy;
		end
	end

	// hold interrupts off for a main-routine read so the latch is not overwritten
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			intBlock <= 1'b0;
		end else if (execRead && !inInterrupt) begin
			intBlock <= 1'b1;
		end else if (bus.rdDone || bus.rdRefused) begin
			intBlock <= 1'b0;
		end
	end
endmodule // pfta_core_end
`default_nettype wire

// ===== test/pfta_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module pfta_monitor
	import pfta_pkg::*;
#(
	parameter bit LARGE = 1'b0
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ptrWr,
	input wire logic rdReq,
	input wire logic rdExt,
	input wire logic [1:0] rdSector,
	input wire logic iapReq,
	input wire pfta_op_t iapOp,
	input wire logic busy,
	input wire logic rdDone,
	input wire logic rdRefused,
	input wire logic [7:0] ptrLow,
	input wire logic [7:0] ptrHigh,
	input wire logic bootValid,
	input wire logic [13:0] bootAddr,
	input wire logic iapDone
);
	// one word per edge after the taking edge, then the edge that samples done
	localparam int PAGE_SPAN = LARGE ? 65 : 33;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	chk_boot_vector: assert property (bootValid |-> bootAddr == 14'h0000 && $past(busy) && !busy)
		else $error("boot fetch not from word zero");
	chk_read_timing: assert property ((rdReq && !busy && (rdExt || rdSector == 2'b00)) |=> busy ##2 rdDone)
		else $error("table read not done in two cycles");
	chk_sector_refuse: assert property ((rdReq && !busy && !rdExt && rdSector != 2'b00) |=> (rdRefused && !rdDone))
		else $error("normal read outside sector zero not refused");
	chk_done_pulse: assert property (rdDone |=> !rdDone)
		else $error("read done longer than one cycle");
	chk_done_idle: assert property (rdDone |-> !busy && $past(busy, 2))
		else $error("read done without two busy cycles");
	chk_ptr_stable: assert property (!ptrWr |=> $stable({ptrHigh, ptrLow}))
		else $error("pointer moved without a write");
	chk_iap_single: assert property ((iapReq && !busy && !rdReq && iapOp == PFTA_OP_READ) |-> ##3 iapDone ##1 !iapDone)
		else $error("programming read not one word");
	chk_page_span: assert property ((iapReq && !busy && !rdReq && (iapOp == PFTA_OP_WRITE || iapOp == PFTA_OP_ERASE)) |-> ##PAGE_SPAN iapDone)
		else $error("page operation length wrong");
endmodule // pfta_monitor
`default_nettype wire

// ===== test/test_program_flash_table_access.sv
`timescale 1ns/100ps
`default_nettype none
module test_program_flash_table_access;
	import pfta_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [5:0] strobe = '0;
	logic [7:0] wrValue = '0;
	logic [7:0] destAddr = '0;
	logic [1:0] destSector = '0;
	logic inInterrupt = 1'b0;
	pfta_op_t iapKind = PFTA_OP_NONE;
	logic [13:0] iapTarget = '0;
	logic [15:0] iapWord = '0;
	logic progActive = 1'b0;
	logic serialClk = 1'b0;
	logic serialDataIn = 1'b0;
	logic pinShareOe = 1'b0;
	logic pinShareOut = 1'b0;
	int blockCount = 0;
	logic dmWr, intBlock, ready, serialDataOut, serialDataOe;
	logic [7:0] dmAddr, dmData, latchRead, serialBitCount, gotAddr, gotData;
	logic [15:0] serialWord;
	logic [15:0] mem [int];
	int fails = 0;
	int comparisons = 0;
	int cycles = 0;
	int seed = 32'h3e9f;
	pfta_if bus ();
	pfta_device #(.LARGE(1'b0), .EMULATION(1'b0)) pfta_device_inst (
		.clk(clk), .sys_rst(sys_rst), .bus(bus), .progActive(progActive),
		.serialClk(serialClk), .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
		.serialDataOe(serialDataOe), .pinShareOut(pinShareOut), .pinShareOe(pinShareOe),
		.serialWord(serialWord), .serialBitCount(serialBitCount));
	pfta_core_end pfta_core_end_inst (
		.clk(clk), .sys_rst(sys_rst), .bus(bus), .setPtrLow(strobe[5]), .setPtrHigh(strobe[4]),
		.setLatch(strobe[3]), .wrValue(wrValue), .execRead(strobe[2]), .destAddr(destAddr),
		.destSector(destSector), .inInterrupt(inInterrupt), .iapStart(strobe[1]),
		.iapKind(iapKind), .iapTarget(iapTarget), .iapPush(strobe[0]), .iapWord(iapWord),
		.dmWr(dmWr), .dmAddr(dmAddr), .dmData(dmData), .intBlock(intBlock),
		.latchRead(latchRead), .ready(ready));
	pfta_monitor #(.LARGE(1'b0)) pfta_monitor_inst (
		.clk(clk), .sys_rst(sys_rst), .ptrWr(bus.ptrWr), .rdReq(bus.rdReq), .rdExt(bus.rdExt),
		.rdSector(bus.rdSector), .iapReq(bus.iapReq), .iapOp(bus.iapOp), .busy(bus.busy),
		.rdDone(bus.rdDone), .rdRefused(bus.rdRefused), .ptrLow(bus.ptrLow),
		.ptrHigh(bus.ptrHigh), .bootValid(bus.bootValid), .bootAddr(bus.bootAddr),
		.iapDone(bus.iapDone));

	initial begin
		forever #50 clk = ~clk;
	end

	// the data write is a one-cycle pulse, so catch it as it passes
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (intBlock === 1'b1) begin
			blockCount <= blockCount + 1;
		end
		if (dmWr === 1'b1) begin
			gotAddr <= dmAddr;
			gotData <= dmData;
		end
		if (cycles == 20000) begin
			fails++;
			give_verdict;
		end
	end

	task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task give_verdict;
		if (fails == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// strobe bits: ptr low, ptr high, latch, read, programming start, word push
	task go(input logic [5:0] sel);
		int n;
		@(posedge clk);
		strobe <= sel;
		@(posedge clk);
		strobe <= '0;
		repeat (3) @(posedge clk);
		for (n = 0; n < 300 && ready !== 1'b1; n++)
			@(posedge clk);
		repeat (2) @(posedge clk);
	endtask

	task in_application_programming(input pfta_op_t k, input logic [13:0] a);
		iapKind <= k;
		iapTarget <= a;
		go(6'h02);
	endtask

	task tread(input logic [13:0] a, input logic [1:0] sec);
		logic [7:0] d;
		int b;
		d = 8'($random(seed));
		wrValue <= a[7:0];
		go(6'h20);
		wrValue <= {2'b00, a[13:8]};
		go(6'h10);
		destAddr <= d;
		destSector <= sec;
		inInterrupt <= sec[0];
		b = blockCount;
		go(6'h04);
		check("int block", {15'h0000, blockCount != b}, {15'h0000, !sec[0]});
		check("int free", {15'h0000, intBlock}, 16'h0000);
		check("dest addr", {8'h00, gotAddr}, {8'h00, d});
		check("low byte", {8'h00, gotData}, {8'h00, mem[a][7:0]});
		check("high byte", {8'h00, latchRead}, {8'h00, mem[a][15:8]});
		check("pointer", {bus.ptrHigh, bus.ptrLow}, {2'b00, a});
	endtask

	initial begin
		logic [13:0] base;
		logic [15:0] w;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk);
		for (int p = 0; p < 2; p++) begin
			base = p ? 14'h1f00 : 14'h0000;
			for (int i = 0; i < 32; i++) begin
				w = (i == 6) ? 16'h0000 : 16'($random(seed));
				mem[base + i] = w;
				iapWord <= w;
				go(6'h01);
			end
			in_application_programming(PFTA_OP_WRITE, base);
		end
		for (int k = 0; k < 8; k++)
			tread(14'h1f00 | 14'((k == 0) ? 6 : ($random(seed) & 31)), 2'(k));
		tread(14'h0000, 2'b00);
		tread(14'h001f, 2'b11);
		in_application_programming(PFTA_OP_READ, 14'h1f1f);
		check("iap word", bus.iapData, mem[14'h1f1f]);
		wrValue <= 8'($random(seed));
		go(6'h08);
		check("latch", {8'h00, latchRead}, {8'h00, wrValue});
		in_application_programming(PFTA_OP_ERASE, 14'h1f00);
		for (int i = 0; i < 32; i++)
			mem[14'h1f00 + i] = 16'hffff;
		tread(14'h1f1f, 2'b01);
		tread(14'h1f00, 2'b00);
		// reset mid-run: memory must survive and fetch restarts at word zero
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk);
		check("boot word", bus.bootWord, mem[0]);
		pinShareOe <= 1'b1;
		pinShareOut <= 1'b1;
		repeat (4) @(posedge clk);
		check("oe idle", {15'h0000, serialDataOe}, 16'h0001);
		check("pin out", {15'h0000, serialDataOut}, 16'h0001);
		progActive <= 1'b1;
		for (int b = 0; b < 8; b++) begin
			serialDataIn <= b[0];
			repeat (4) @(posedge clk);
			serialClk <= 1'b1;
			repeat (4) @(posedge clk);
			serialClk <= 1'b0;
		end
		repeat (4) @(posedge clk);
		check("oe prog", {15'h0000, serialDataOe}, 16'h0000);
		check("bit count", {8'h00, serialBitCount}, 16'h0008);
		check("serial word", serialWord, 16'h0055);
		give_verdict;
	end
endmodule // test_program_flash_table_access
`default_nettype wire
